// ==== apc_regs.sv ====
// Control register bank for the analogue mixer, line output, speaker and power.
// Assumes a control port that issues one-cycle read and write strobes on core_clk,
// and an over-temperature flag from the analogue sensor, asynchronous to core_clk.
`timescale 1ns/100ps
`include "apc_defs.svh"

module apc_regs (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// Register access
	input wire apc_pkg::apc_bus_t bus,
	output logic [`APC_DATA_W-1:0] rdata,
	output logic rvalid,
	// Analogue side
	input wire logic over_temp_pin,
	output apc_pkg::apc_ctrl_t ctrl
);
	import apc_pkg::*;

	logic [`APC_DATA_W-1:0] r_ref;
	logic [`APC_DATA_W-1:0] r_mix;
	logic [`APC_DATA_W-1:0] r_pop;
	logic [`APC_DATA_W-1:0] r_boost;
	logic [`APC_DATA_W-1:0] r_mode;
	logic [`APC_DATA_W-1:0] r_pwr;
	logic hot_q;
	logic hot_status;
	logic [`APC_DATA_W-1:0] next_rdata;
	apc_ctrl_t next_ctrl;

	// ****************************************************************
	// Sensor flag synchroniser
	// ****************************************************************
	apc_temp_sync #(
		.STAGES(3)
	) u_temp_sync (
		.core_clk(core_clk),
		.rst(rst),
		.async_in(over_temp_pin),
		.sync_out(hot_q)
	);

	// Status means nothing while the sensor is powered down
	assign hot_status = hot_q & r_pwr[`APC_B_TSENSE];

	// ****************************************************************
	// Effective control decode
	// ****************************************************************
	function automatic apc_ctrl_t ctrl_of(
		input logic [`APC_DATA_W-1:0] rf,
		input logic [`APC_DATA_W-1:0] mx,
		input logic [`APC_DATA_W-1:0] pp,
		input logic [`APC_DATA_W-1:0] bs,
		input logic [`APC_DATA_W-1:0] md,
		input logic [`APC_DATA_W-1:0] pw,
		input logic hot
	);
		apc_ctrl_t c;
		logic trip;
		logic spk_on;
		trip = pw[`APC_B_TSHUT] & pw[`APC_B_TSENSE] & hot;
		spk_on = pw[`APC_B_SPK_ON] & ~trip;
		c.midpoint_buffer_on = rf[`APC_B_MIDBUF];
		c.dac_path_on = mx[`APC_B_DAC_PATH];
		c.input_two_attenuate = mx[`APC_B_IN2_ATT];
		c.input_two_path_on = mx[`APC_B_IN2_ON];
		c.input_one_attenuate = mx[`APC_B_IN1_ATT];
		c.input_one_path_on = mx[`APC_B_IN1_ON];
		c.line_output_discharge = pp[`APC_B_DISCHARGE];
		// Clamp uses the enable bit, not the tripped state, as a shutdown is not a user disable
		c.line_clamp_active = pp[`APC_B_CLAMP] & ~pw[`APC_B_LINE_ON];
		c.line_clamp_resistance_sel = pp[`APC_B_CLAMP_RES] & c.line_clamp_active;
		c.speaker_dc_boost = bs[`APC_F_DC_HI:`APC_F_DC_LO];
		c.speaker_ac_boost = bs[`APC_F_AC_HI:`APC_F_AC_LO];
		c.speaker_class_select = md[`APC_B_CLASS];
		// Class D drives suppression itself; class AB trusts software ordering
		c.speaker_popsup_a = md[`APC_B_CLASS] ? md[`APC_B_POPSUP_A] : ~spk_on;
		c.speaker_popsup_b = md[`APC_B_CLASS] ? md[`APC_B_POPSUP_B] : ~spk_on;
		c.thermal_sensor_on = pw[`APC_B_TSENSE];
		c.over_temp = hot & pw[`APC_B_TSENSE];
		c.line_output_on = pw[`APC_B_LINE_ON] & ~trip;
		c.speaker_preamp_on = pw[`APC_B_PREAMP_ON] & ~trip;
		c.speaker_output_on = spk_on;
		c.converter_on = pw[`APC_B_CONV_ON];
		return c;
	endfunction

	assign next_ctrl = ctrl_of(r_ref, r_mix, r_pop, r_boost, r_mode, r_pwr, hot_q);

	// Controls leave on a flop so the analogue side never sees decode glitches
	always_ff @(posedge core_clk) begin
		if (rst) begin
			ctrl <= ctrl_of(`APC_RST_REFERENCE, `APC_RST_MIXER, `APC_RST_ANTIPOP,
				`APC_RST_BOOST, `APC_RST_MODE, `APC_RST_POWER, 1'b0);
		end else begin
			ctrl <= next_ctrl;
		end
	end

	// ****************************************************************
	// Register writes
	// ****************************************************************
	// Masked store; unmapped offsets and undefined bits are dropped
	always_ff @(posedge core_clk) begin
		if (rst) begin
			r_ref <= `APC_RST_REFERENCE;
			r_mix <= `APC_RST_MIXER;
			r_pop <= `APC_RST_ANTIPOP;
			r_boost <= `APC_RST_BOOST;
			r_mode <= `APC_RST_MODE;
			r_pwr <= `APC_RST_POWER;
		end else if (bus.wr) begin
			unique case (bus.addr)
				`APC_OFS_REFERENCE: r_ref <= bus.wdata & `APC_MSK_REFERENCE;
				`APC_OFS_MIXER: r_mix <= bus.wdata & `APC_MSK_MIXER;
				`APC_OFS_ANTIPOP: r_pop <= bus.wdata & `APC_MSK_ANTIPOP;
				`APC_OFS_BOOST: r_boost <= bus.wdata & `APC_MSK_BOOST;
				`APC_OFS_MODE: r_mode <= bus.wdata & `APC_MSK_MODE;
				`APC_OFS_POWER: r_pwr <= bus.wdata & `APC_MSK_POWER;
				default: ;
			endcase
		end
	end

	// ****************************************************************
	// Register reads
	// ****************************************************************
	always_comb begin
		unique case (bus.addr)
			`APC_OFS_REFERENCE: next_rdata = r_ref;
			`APC_OFS_MIXER: next_rdata = r_mix;
			`APC_OFS_ANTIPOP: next_rdata = r_pop;
			`APC_OFS_BOOST: next_rdata = r_boost;
			`APC_OFS_MODE: next_rdata = r_mode;
			`APC_OFS_POWER: next_rdata = r_pwr | ({{(`APC_DATA_W-1){1'b0}}, hot_status}
				<< `APC_B_HOT);
			default: next_rdata = '0;
		endcase
	end

	// Read data held until the next read
	always_ff @(posedge core_clk) begin
		if (rst) begin
			rdata <= '0;
			rvalid <= 1'b0;
		end else begin
			rvalid <= bus.rd;
			if (bus.rd) begin
				rdata <= next_rdata;
			end
		end
	end

	// ****************************************************************
	// Assertions
	// ****************************************************************
	property p_dac_path;
		@(posedge core_clk) disable iff (rst)
		(bus.wr && bus.addr == `APC_OFS_MIXER) |=> ##1
			ctrl.dac_path_on == $past(bus.wdata[`APC_B_DAC_PATH], 2);
	endproperty
	a_dac_path: assert property (p_dac_path) else $error("mixer path bit not applied");

	property p_in_att;
		@(posedge core_clk) disable iff (rst)
		(bus.wr && bus.addr == `APC_OFS_MIXER) |=> ##1
			{ctrl.input_two_attenuate, ctrl.input_two_path_on, ctrl.input_one_attenuate,
			ctrl.input_one_path_on} == $past(bus.wdata[`APC_B_IN2_ATT:`APC_B_IN1_ON], 2);
	endproperty
	a_in_att: assert property (p_in_att) else $error("input path bits not applied");

	property p_discharge;
		@(posedge core_clk) disable iff (rst)
		(bus.wr && bus.addr == `APC_OFS_ANTIPOP) |=> ##1
			ctrl.line_output_discharge == $past(bus.wdata[`APC_B_DISCHARGE], 2);
	endproperty
	a_discharge: assert property (p_discharge) else $error("discharge bit not applied");

	property p_clamp_res;
		@(posedge core_clk) disable iff (rst)
		ctrl.line_clamp_resistance_sel |-> ctrl.line_clamp_active && !ctrl.line_output_on;
	endproperty
	a_clamp_res: assert property (p_clamp_res) else $error("resistance select outside clamp");

	property p_clamp_gate;
		@(posedge core_clk) disable iff (rst)
		r_pwr[`APC_B_LINE_ON] |=> !ctrl.line_clamp_active;
	endproperty
	a_clamp_gate: assert property (p_clamp_gate) else $error("clamp active with line enabled");

	property p_boost_reset;
		@(posedge core_clk)
		$fell(rst) |-> ctrl.speaker_dc_boost == 3'h3 && ctrl.speaker_ac_boost == 3'h3
			&& r_boost == `APC_RST_BOOST;
	endproperty
	a_boost_reset: assert property (p_boost_reset) else $error("boost reset value wrong");

	property p_ac_boost;
		@(posedge core_clk) disable iff (rst)
		(bus.wr && bus.addr == `APC_OFS_BOOST) |=> ##1
			ctrl.speaker_ac_boost == $past(bus.wdata[`APC_F_AC_HI:`APC_F_AC_LO], 2);
	endproperty
	a_ac_boost: assert property (p_ac_boost) else $error("ac boost not applied");

	property p_class;
		@(posedge core_clk) disable iff (rst)
		(bus.wr && bus.addr == `APC_OFS_MODE) |=> ##1
			ctrl.speaker_class_select == $past(bus.wdata[`APC_B_CLASS], 2);
	endproperty
	a_class: assert property (p_class) else $error("speaker class not applied");

	property p_popsup_d;
		@(posedge core_clk) disable iff (rst)
		!ctrl.speaker_class_select |-> ctrl.speaker_popsup_a == !ctrl.speaker_output_on
			&& ctrl.speaker_popsup_b == !ctrl.speaker_output_on;
	endproperty
	a_popsup_d: assert property (p_popsup_d) else $error("class D suppression not automatic");

	property p_shutdown;
		@(posedge core_clk) disable iff (rst)
		(hot_q && r_pwr[`APC_B_TSHUT] && r_pwr[`APC_B_TSENSE]) |=>
			!ctrl.line_output_on && !ctrl.speaker_output_on && !ctrl.speaker_preamp_on;
	endproperty
	a_shutdown: assert property (p_shutdown) else $error("outputs not forced off when hot");

	property p_sensor;
		@(posedge core_clk) disable iff (rst)
		!r_pwr[`APC_B_TSENSE] |=> !ctrl.thermal_sensor_on && !ctrl.over_temp;
	endproperty
	a_sensor: assert property (p_sensor) else $error("sensor still on");

	property p_status;
		@(posedge core_clk) disable iff (rst)
		(bus.rd && bus.addr == `APC_OFS_POWER) |=> rdata[`APC_B_HOT] == $past(hot_status);
	endproperty
	a_status: assert property (p_status) else $error("status bit wrong");

	property p_conv;
		@(posedge core_clk) disable iff (rst)
		(bus.wr && bus.addr == `APC_OFS_POWER) |=> ##1
			ctrl.converter_on == $past(bus.wdata[`APC_B_CONV_ON], 2);
	endproperty
	a_conv: assert property (p_conv) else $error("converter enable not applied");

	property p_midbuf;
		@(posedge core_clk) disable iff (rst)
		(bus.wr && bus.addr == `APC_OFS_REFERENCE) |=> ##1
			ctrl.midpoint_buffer_on == $past(bus.wdata[`APC_B_MIDBUF], 2);
	endproperty
	a_midbuf: assert property (p_midbuf) else $error("midpoint buffer not applied");

	property p_undef;
		@(posedge core_clk) disable iff (rst)
		(bus.rd && bus.addr == `APC_OFS_MIXER) |=>
			rdata[`APC_DATA_W-1:`APC_B_DAC_PATH+1] == '0 && rvalid;
	endproperty
	a_undef: assert property (p_undef) else $error("undefined bits not zero");

endmodule

// ==== apc_defs.svh ====
// Constants for the analogue path and power control register bank.
// Assumes inclusion by bare name from the package and the modules.
`ifndef APC_DEFS_SVH
`define APC_DEFS_SVH

// ****************************************************************
// Register offsets
// ****************************************************************
`define APC_ADDR_W 8
`define APC_DATA_W 16
`define APC_OFS_REFERENCE 8'h04
`define APC_OFS_MIXER 8'h07
`define APC_OFS_ANTIPOP 8'h08
`define APC_OFS_BOOST 8'h09
`define APC_OFS_MODE 8'h0a
`define APC_OFS_POWER 8'h0b

// ****************************************************************
// Reset values and writable bit masks
// ****************************************************************
`define APC_RST_REFERENCE 16'h0000
`define APC_RST_MIXER 16'h0000
`define APC_RST_ANTIPOP 16'h0000
`define APC_RST_BOOST 16'h001b
`define APC_RST_MODE 16'h0018
`define APC_RST_POWER 16'h0180
`define APC_MSK_REFERENCE 16'h0020
`define APC_MSK_MIXER 16'h001f
`define APC_MSK_ANTIPOP 16'h0007
`define APC_MSK_BOOST 16'h003f
`define APC_MSK_MODE 16'h0058
`define APC_MSK_POWER 16'h0197

// ****************************************************************
// Field positions
// ****************************************************************
`define APC_B_MIDBUF 5
`define APC_B_DAC_PATH 4
`define APC_B_IN2_ATT 3
`define APC_B_IN2_ON 2
`define APC_B_IN1_ATT 1
`define APC_B_IN1_ON 0
`define APC_B_DISCHARGE 2
`define APC_B_CLAMP_RES 1
`define APC_B_CLAMP 0
`define APC_F_DC_HI 5
`define APC_F_DC_LO 3
`define APC_F_AC_HI 2
`define APC_F_AC_LO 0
`define APC_B_CLASS 6
`define APC_B_POPSUP_A 4
`define APC_B_POPSUP_B 3
`define APC_B_TSHUT 8
`define APC_B_TSENSE 7
`define APC_B_HOT 6
`define APC_B_LINE_ON 4
`define APC_B_PREAMP_ON 2
`define APC_B_SPK_ON 1
`define APC_B_CONV_ON 0

`endif

// ==== apc_pkg.sv ====
// Types shared by the control register bank and its users.
// Assumes the constants header sits in the include path.
`include "apc_defs.svh"

package apc_pkg;

	// ****************************************************************
	// Register access request from the control port
	// ****************************************************************
	typedef struct packed {
		logic wr;
		logic rd;
		logic [`APC_ADDR_W-1:0] addr;
		logic [`APC_DATA_W-1:0] wdata;
	} apc_bus_t;

	// ****************************************************************
	// Effective controls to the analogue circuitry
	// ****************************************************************
	typedef struct packed {
		logic midpoint_buffer_on;
		logic dac_path_on;
		logic input_two_attenuate;
		logic input_two_path_on;
		logic input_one_attenuate;
		logic input_one_path_on;
		logic line_output_discharge;
		logic line_clamp_active;
		logic line_clamp_resistance_sel;
		logic [2:0] speaker_dc_boost;
		logic [2:0] speaker_ac_boost;
		logic speaker_class_select;
		logic speaker_popsup_a;
		logic speaker_popsup_b;
		logic thermal_sensor_on;
		logic over_temp;
		logic line_output_on;
		logic speaker_preamp_on;
		logic speaker_output_on;
		logic converter_on;
	} apc_ctrl_t;

endpackage

// ==== apc_temp_sync.sv ====
// Three-stage synchroniser with agreement filter for the sensor flag.
// Assumes an asynchronous level input and a synchronous active-high reset.
`timescale 1ns/100ps

module apc_temp_sync #(
	parameter int STAGES = 3
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// Level in and filtered level out
	input wire logic async_in,
	output logic sync_out
);

	logic [STAGES-1:0] chain;

	// ****************************************************************
	// Elaboration check
	// ****************************************************************
	if (STAGES < 3) begin : g_bad_stages
		$error("apc_temp_sync needs at least three stages");
	end

	// Shift chain; only the next stage reads the first flop
	always_ff @(posedge core_clk) begin
		if (rst) begin
			chain <= '0;
		end else begin
			chain <= {chain[STAGES-2:0], async_in};
		end
	end

	// Accept a change once the last two stages agree
	always_ff @(posedge core_clk) begin
		if (rst) begin
			sync_out <= 1'b0;
		end else if (chain[STAGES-1] == chain[STAGES-2]) begin
			sync_out <= chain[STAGES-1];
		end
	end

endmodule

// ==== analog_path_power_control_regs_tb_top.sv ====
// Self-checking bench for the analogue path and power control bank.
// Assumes apc_pkg and apc_regs are compiled first; assertions live in the design.
`timescale 1ns/100ps
`include "apc_defs.svh"

// One comparison: counts it, reports and counts a mismatch
`define CHK(nm, e, g) begin \
	cmp_count++; \
	if ((g) !== (e)) begin \
		errors++; \
		$display("unexpected %s expected %h seen %h", nm, e, g); \
	end \
end

module analog_path_power_control_regs_tb_top;
	import apc_pkg::*;

	logic core_clk;
	logic rst;
	apc_bus_t bus;
	logic [15:0] rdata;
	logic rvalid;
	logic over_temp_pin;
	apc_ctrl_t ctrl;
	int errors = 0;
	int cmp_count = 0;

	apc_regs i_apc_regs (
		.core_clk(core_clk),
		.rst(rst),
		.bus(bus),
		.rdata(rdata),
		.rvalid(rvalid),
		.over_temp_pin(over_temp_pin),
		.ctrl(ctrl)
	);

	// ****************************************************************
	// Clock, verdict and bus tasks
	// ****************************************************************
	// 100 MHz clock
	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end

	task automatic results();
		$display("comparisons %0d mismatches %0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	// Output enables in one word: line, preamp, speaker, converter
	function automatic logic [3:0] outs_of(input apc_ctrl_t c);
		return {c.line_output_on, c.speaker_preamp_on, c.speaker_output_on, c.converter_on};
	endfunction

	// Mixer controls in register bit order
	function automatic logic [4:0] mix_of(input apc_ctrl_t c);
		return {c.dac_path_on, c.input_two_attenuate, c.input_two_path_on,
			c.input_one_attenuate, c.input_one_path_on};
	endfunction

	// Write, then wait three edges after the strobe edge, long enough for ctrl to follow (it needs one)
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge core_clk);
		bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(posedge core_clk);
		bus.wr <= 1'b0;
		repeat (3) @(posedge core_clk);
		#1;
	endtask

	// Read with a bounded wait on rvalid
	task automatic rd(input logic [7:0] a, output logic [15:0] d);
		int n;
		@(posedge core_clk);
		bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
		@(posedge core_clk);
		bus.rd <= 1'b0;
		#1;
		n = 0;
		while (rvalid !== 1'b1 && n < 4) begin
			@(posedge core_clk);
			#1;
			n++;
		end
		if (rvalid !== 1'b1) begin
			$display("unexpected rvalid expected 1 seen %b", rvalid);
			errors++;
			results();
		end
		d = rdata;
	endtask

	task automatic chk_rd(input logic [7:0] a, input logic [15:0] e);
		logic [15:0] d;
		rd(a, d);
		`CHK("rdata", e, d)
	endtask

	// ****************************************************************
	// Scenarios
	// ****************************************************************
	task automatic t_reset();
		apc_ctrl_t e;
		e = '0;
		e.speaker_dc_boost = 3'h3;
		e.speaker_ac_boost = 3'h3;
		e.speaker_popsup_a = 1'b1;
		e.speaker_popsup_b = 1'b1;
		e.thermal_sensor_on = 1'b1;
		`CHK("ctrl", e, ctrl)
		chk_rd(8'h07, 16'h0000);
		chk_rd(8'h08, 16'h0000);
		chk_rd(8'h09, 16'h001b);
		chk_rd(8'h0a, 16'h0018);
		chk_rd(8'h0b, 16'h0180);
		chk_rd(8'h04, 16'h0000);
	endtask

	// All ones then all zeros; only defined bits stick
	task automatic t_masks();
		logic [7:0] a [6] = '{8'h04, 8'h07, 8'h08, 8'h09, 8'h0a, 8'h0b};
		logic [15:0] m [6] = '{16'h0020, 16'h001f, 16'h0007, 16'h003f, 16'h0058, 16'h0197};
		for (int i = 0; i < 6; i++) begin
			wr(a[i], 16'hffff);
			chk_rd(a[i], m[i]);
			wr(a[i], 16'h0000);
			chk_rd(a[i], 16'h0000);
		end
		wr(8'h05, 16'hffff);
		chk_rd(8'h05, 16'h0000);
	endtask

	task automatic t_mixer();
		for (int i = 0; i < 32; i++) begin
			wr(8'h07, 16'(i));
			`CHK("mixer", 5'(i), mix_of(ctrl))
		end
	endtask

	// Clamp acts only with the line output off; resistance only while clamping
	task automatic t_antipop();
		logic [3:0] v;
		// Buffer first, as software must before relying on the clamp
		wr(8'h04, 16'h0020);
		for (int i = 0; i < 16; i++) begin
			v = 4'(i);
			wr(8'h0b, {11'h0, v[3], 4'h0});
			wr(8'h08, {13'h0, v[2:0]});
			`CHK("discharge", v[2], ctrl.line_output_discharge)
			`CHK("clamp", v[0] & ~v[3], ctrl.line_clamp_active)
			`CHK("clamp_res", v[1] & v[0] & ~v[3], ctrl.line_clamp_resistance_sel)
			`CHK("line_on", v[3], ctrl.line_output_on)
		end
		wr(8'h04, 16'h0000);
		`CHK("midbuf", 1'b0, ctrl.midpoint_buffer_on)
	endtask

	task automatic t_boost();
		logic [2:0] c;
		for (int i = 0; i < 8; i++) begin
			c = 3'(i);
			wr(8'h09, {10'h0, c, ~c});
			`CHK("dc_boost", c, ctrl.speaker_dc_boost)
			`CHK("ac_boost", ~c, ctrl.speaker_ac_boost)
		end
	endtask

	// Class D: suppression follows the speaker enable; class AB: registers
	task automatic t_popsup();
		wr(8'h0a, 16'h0018);
		wr(8'h0b, 16'h0006);
		`CHK("popsup", 2'b00, {ctrl.speaker_popsup_a, ctrl.speaker_popsup_b})
		`CHK("class", 1'b0, ctrl.speaker_class_select)
		wr(8'h0b, 16'h0004);
		`CHK("popsup", 2'b11, {ctrl.speaker_popsup_a, ctrl.speaker_popsup_b})
		wr(8'h0a, 16'h0040);
		`CHK("class", 1'b1, ctrl.speaker_class_select)
		`CHK("popsup", 2'b00, {ctrl.speaker_popsup_a, ctrl.speaker_popsup_b})
		wr(8'h0b, 16'h0006);
		`CHK("spk_on", 2'b11, {ctrl.speaker_output_on, ctrl.speaker_preamp_on})
		wr(8'h0a, 16'h0050);
		`CHK("popsup", 2'b10, {ctrl.speaker_popsup_a, ctrl.speaker_popsup_b})
		chk_rd(8'h0a, 16'h0050);
	endtask

	task automatic t_thermal();
		int n;
		wr(8'h0b, 16'h0197);
		@(posedge core_clk);
		over_temp_pin <= 1'b1;
		n = 0;
		while (ctrl.over_temp !== 1'b1 && n < 20) begin
			@(posedge core_clk);
			#1;
			n++;
		end
		if (n >= 20) begin
			$display("unexpected over_temp expected 1 seen %b", ctrl.over_temp);
			errors++;
			results();
		end
		repeat (2) @(posedge core_clk);
		#1;
		`CHK("outs_tripped", 4'b0001, outs_of(ctrl))
		chk_rd(8'h0b, 16'h01d7);
		wr(8'h0b, 16'h0097);
		`CHK("outs_no_shut", 4'b1111, outs_of(ctrl))
		wr(8'h0b, 16'h0117);
		`CHK("sensor", 2'b00, {ctrl.thermal_sensor_on, ctrl.over_temp})
		`CHK("outs_no_sense", 1'b1, ctrl.speaker_output_on)
		chk_rd(8'h0b, 16'h0117);
		// Cool down: status and outputs come back once the flag settles
		@(posedge core_clk);
		over_temp_pin <= 1'b0;
		wr(8'h0b, 16'h0197);
		repeat (4) @(posedge core_clk);
		#1;
		chk_rd(8'h0b, 16'h0197);
		`CHK("outs_cooled", 4'b1111, outs_of(ctrl))
	endtask

	// Reset in mid-run restores every default
	task automatic t_rerst();
		wr(8'h09, 16'h0005);
		wr(8'h0a, 16'h0040);
		wr(8'h0b, 16'h0017);
		@(posedge core_clk);
		rst <= 1'b1;
		repeat (3) @(posedge core_clk);
		rst <= 1'b0;
		#1;
		t_reset();
	endtask

	// Midpoint buffer, and a read in the same cycle as a write
	task automatic t_misc();
		wr(8'h04, 16'h0020);
		`CHK("midbuf", 1'b1, ctrl.midpoint_buffer_on)
		wr(8'h07, 16'h0000);
		@(posedge core_clk);
		bus <= '{wr: 1'b1, rd: 1'b1, addr: 8'h07, wdata: 16'h0015};
		@(posedge core_clk);
		bus <= '{wr: 1'b0, rd: 1'b0, addr: 8'h07, wdata: 16'h0000};
		#1;
		`CHK("old_rdata", 16'h0000, rdata)
		`CHK("rvalid", 1'b1, rvalid)
		@(posedge core_clk);
		#1;
		`CHK("rvalid", 1'b0, rvalid)
		chk_rd(8'h07, 16'h0015);
	endtask

	// ****************************************************************
	// Main sequence
	// ****************************************************************
	initial begin
		rst = 1'b1;
		bus = '0;
		over_temp_pin = 1'b0;
		repeat (3) @(posedge core_clk);
		rst <= 1'b0;
		#1;
		t_reset();
		t_masks();
		t_mixer();
		t_antipop();
		t_boost();
		t_popsup();
		t_thermal();
		t_rerst();
		t_misc();
		results();
	end
endmodule
